// ==== design/prs_sequence_timing.sv ====
// Start-up timeout supervision, fault response and soft-off timing of one rail
`timescale 1ns/1ps
// What this block does
// - Timeout runs from end of turn-on wait until output reaches 85% of target.
// - Undervoltage detection is armed only when the ramp-up time ends.
// - Timeout limit is linear: exponent bits 15:11 reset 11111b, mantissa bits 10:0.
// - Timeout limit covers zero to 127 ms in half-millisecond steps.
// - A zero timeout limit turns start-up supervision off.
// - Writing the timeout limit is an invalid command, flagged, host alerted.
// - Timeout fault sets other-summary, status word output bit, timeout bit, alert.
// - Action bits 7:6: ignore, delayed shutdown, immediate shutdown; 11b is invalid.
// - Retry bits 5:3: zero latches off, 1-6 retries, 7 retries forever.
// - Delay bits 2:0 give shutdown delay in ms and restart_wait_period multiple of ramp-up, code 0 counting as 1.
// - Unsupported action byte is flagged as invalid data and alerts the host.
// - Action is one byte, read and written, applied while running.
// - Stop delay runs from stop condition until ramp-down starts; energy transfer stops when the fall ends.
// - Stop delay is zero to 127.5 ms in half-ms steps; others invalid.
// - A fixed internal latency is added to every stop delay, even zero.
// - Ramp-down runs from end of stop delay until reference reaches zero.
// - Fall duration equals the programmed time, below 0.5 ms taken as 0.5 ms, whatever the target voltage.
// - Ramp-up time steps are quarter ms, below 0.5 ms taken as 0.5 ms.
module prs_sequence_timing #(
  parameter int unsigned QUARTER_CYCLES = prs_pkg::QUARTER_MS_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 runRequest,
  input  wire logic                 turnOnWaitDone,
  input  wire logic                 rampUpDone,
  input  wire logic [10:0]          rampUpQuarters,
  input  wire logic [15:0]          outputVoltageTelemetry,
  input  wire logic [15:0]          targetVoltage,
  input  wire logic                 clearFaults,
  input  wire prs_pkg::prs_cmd_t    cmd,
  output logic      [15:0]          cmdReadData,
  output logic                      cmdReadValid,
  output logic                      energyOn,
  output logic                      undervoltageArm,
  output logic      [15:0]          referenceLevel,
  output prs_pkg::prs_status_t      status,
  output logic                      alertN
);

  typedef enum logic [3:0] {
    ST_OFF, ST_WAIT_ON, ST_RISE, ST_RESP_DELAY, ST_RUN,
    ST_STOP_DELAY, ST_LATENCY, ST_FALL, ST_RESTART_WAIT_PERIOD, ST_LATCHED
  } prs_state_t;

  prs_state_t  state_q, state_d;
  logic        runMeta_q, runSync_q;
  logic [15:0] limitReg_q, stopReg_q, fallReg_q;
  logic [7:0]  actionReg_q;
  logic [13:0] cycleCnt_q;
  logic [15:0] quarterCnt_q;
  logic [2:0]  retriesLeft_q;
  logic        voutTimeout_q, invalidCmd_q, invalidData_q, uvArm_q, energy_q;
  logic [15:0] refLevel_q;
  logic        quarterTick, latencyDone, reached, faultHit;
  logic [15:0] limitQuarters, stopQuarters, respQuarters, hiccupQuarters;
  logic [10:0] fallQuarters, riseQuarters;
  logic [2:0]  delayCode, retryCode;
  logic        wrEvent, wrLimit, wrAction, wrStop, wrFall, badAction, badStop, badFall;
  logic [22:0] senseScaled, targetScaled;
  logic [31:0] refProduct;
  prs_pkg::prs_action_t actSel;

  // Start/stop pin is asynchronous to clk
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      runMeta_q <= 1'b0;
      runSync_q <= 1'b0;
    end
    else
    begin
      runMeta_q <= runRequest;
      runSync_q <= runMeta_q;
    end
  end

  assign actSel    = prs_pkg::prs_action_t'(actionReg_q[7:prs_pkg::ACT_SEL_LSB]);
  assign retryCode = actionReg_q[5:prs_pkg::ACT_RETRY_LSB];
  assign delayCode = actionReg_q[2:prs_pkg::ACT_DELAY_LSB];

  // Mantissas are in half-ms (limit, stop) and quarter-ms (fall) units
  assign limitQuarters = {4'h0, limitReg_q[10:0], 1'b0};
  assign stopQuarters  = {4'h0, stopReg_q[10:0], 1'b0};
  assign fallQuarters  = (fallReg_q[10:0] < prs_pkg::FALL_MAN_MIN) ? prs_pkg::FALL_MAN_MIN : fallReg_q[10:0];
  assign riseQuarters  = (rampUpQuarters < prs_pkg::RISE_MAN_MIN) ? prs_pkg::RISE_MAN_MIN : rampUpQuarters;
  assign respQuarters  = (delayCode == 3'h0) ? 16'h0004 : {11'h000, delayCode, 2'h0};
  assign hiccupQuarters = (delayCode == 3'h0) ? {5'h00, riseQuarters}
                        : 16'((riseQuarters * delayCode) & 14'h3fff);

  // 85% crossing compared without division
  assign senseScaled  = 23'(outputVoltageTelemetry) * 23'(prs_pkg::REACH_DEN);
  assign targetScaled = 23'(targetVoltage) * 23'(prs_pkg::REACH_NUM);
  assign reached      = senseScaled >= targetScaled;

  assign quarterTick = cycleCnt_q == 14'(QUARTER_CYCLES - 1);
  assign latencyDone = cycleCnt_q == 14'(prs_pkg::LATENCY_CYCLES - 1);
  assign faultHit = state_q == ST_RISE && !reached && limitReg_q[10:0] != 11'h000
                  && quarterCnt_q >= limitQuarters;

  // Command decode; values outside range are refused and never stored
  assign wrEvent  = cmd.valid && cmd.write;
  assign wrLimit  = wrEvent && cmd.code == prs_pkg::CMD_TIMEOUT_LIMIT;
  assign wrAction = wrEvent && cmd.code == prs_pkg::CMD_TIMEOUT_ACTION;
  assign wrStop   = wrEvent && cmd.code == prs_pkg::CMD_STOP_DELAY;
  assign wrFall   = wrEvent && cmd.code == prs_pkg::CMD_RAMP_DOWN;
  assign badAction = cmd.data[7:6] == 2'h3;
  assign badStop = cmd.data[15:11] != prs_pkg::EXP_HALF_MS || cmd.data[10:0] > prs_pkg::STOP_MAN_MAX;
  assign badFall = cmd.data[15:11] != prs_pkg::EXP_QUARTER_MS || cmd.data[10:0] > prs_pkg::FALL_MAN_MAX;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      limitReg_q  <= {prs_pkg::EXP_HALF_MS, prs_pkg::TIMEOUT_MAN_RESET};
      actionReg_q <= prs_pkg::ACTION_RESET;
      stopReg_q   <= {prs_pkg::EXP_HALF_MS, prs_pkg::STOP_MAN_RESET};
      fallReg_q   <= {prs_pkg::EXP_QUARTER_MS, prs_pkg::FALL_MAN_RESET};
    end
    else
    begin
      if (wrAction && !badAction)
        actionReg_q <= cmd.data[7:0];
      if (wrStop && !badStop)
        stopReg_q <= cmd.data;
      if (wrFall && !badFall)
        fallReg_q <= cmd.data;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmdReadData  <= 16'h0000;
      cmdReadValid <= 1'b0;
    end
    else
    begin
      cmdReadValid <= 1'b0;
      if (cmd.valid && !cmd.write)
      begin
        cmdReadValid <= 1'b1;
        if (cmd.code == prs_pkg::CMD_TIMEOUT_LIMIT)
          cmdReadData <= limitReg_q;
        else if (cmd.code == prs_pkg::CMD_TIMEOUT_ACTION)
          cmdReadData <= {8'h00, actionReg_q};
        else if (cmd.code == prs_pkg::CMD_STOP_DELAY)
          cmdReadData <= stopReg_q;
        else if (cmd.code == prs_pkg::CMD_RAMP_DOWN)
          cmdReadData <= fallReg_q;
        else
        begin
          cmdReadValid <= 1'b0;
          cmdReadData  <= 16'h0000;
        end
      end
    end
  end

  // Flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      voutTimeout_q <= 1'b0;
      invalidCmd_q  <= 1'b0;
      invalidData_q <= 1'b0;
    end
    else
    begin
      voutTimeout_q <= faultHit || (voutTimeout_q && !clearFaults);
      invalidCmd_q  <= wrLimit || (invalidCmd_q && !clearFaults);
      invalidData_q <= (wrAction && badAction) || (wrStop && badStop) || (wrFall && badFall)
                     || (invalidData_q && !clearFaults);
    end
  end

  assign status.voutTimeout    = voutTimeout_q;
  assign status.invalidCommand = invalidCmd_q;
  assign status.invalidData    = invalidData_q;
  assign status.summaryOther   = voutTimeout_q;
  assign status.summaryVout    = voutTimeout_q;
  assign status.summaryCml     = invalidCmd_q || invalidData_q;
  assign alertN = !(voutTimeout_q || invalidCmd_q || invalidData_q);

  // Sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:        if (runSync_q) state_d = ST_WAIT_ON;
      ST_WAIT_ON:    if (turnOnWaitDone) state_d = ST_RISE;
      ST_RISE:
        if (reached)
          state_d = ST_RUN;
        else if (faultHit)
        begin
          if (actSel == prs_pkg::ACT_DELAYED)
            state_d = ST_RESP_DELAY;
          else if (actSel == prs_pkg::ACT_IMMEDIATE)
            state_d = (retryCode == 3'h0 || retriesLeft_q == 3'h0) ? ST_LATCHED : ST_RESTART_WAIT_PERIOD;
          else
            state_d = ST_RUN;
        end
      ST_RESP_DELAY:
        if (reached)
          state_d = ST_RUN;
        else if (quarterTick && quarterCnt_q + 16'h0001 >= respQuarters)
          state_d = (retryCode == 3'h0 || retriesLeft_q == 3'h0) ? ST_LATCHED : ST_RESTART_WAIT_PERIOD;
      ST_STOP_DELAY: if (quarterCnt_q >= stopQuarters) state_d = ST_LATENCY;
      ST_LATENCY:    if (latencyDone) state_d = ST_FALL;
      ST_FALL:       if (quarterTick && 11'(quarterCnt_q) + 11'h001 >= fallQuarters) state_d = ST_OFF;
      ST_RESTART_WAIT_PERIOD:     if (quarterCnt_q >= hiccupQuarters) state_d = ST_WAIT_ON;
      default:       state_d = state_q;
    endcase
    // A stop condition cuts any start attempt short
    if (!runSync_q && state_q inside {ST_WAIT_ON, ST_RISE, ST_RESP_DELAY, ST_RUN})
      state_d = ST_STOP_DELAY;
    else if (!runSync_q && state_q inside {ST_RESTART_WAIT_PERIOD, ST_LATCHED})
      state_d = ST_OFF;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  // Shared timer restarts on every state change
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cycleCnt_q   <= 14'h0000;
      quarterCnt_q <= 16'h0000;
    end
    else if (state_d != state_q)
    begin
      cycleCnt_q   <= 14'h0000;
      quarterCnt_q <= 16'h0000;
    end
    else
    begin
      // Latency is counted in plain cycles, so it must not wrap when a quarter is short
      cycleCnt_q <= (quarterTick && state_q != ST_LATENCY) ? 14'h0000 : cycleCnt_q + 14'h0001;
      if (quarterTick && quarterCnt_q != 16'hffff)
        quarterCnt_q <= quarterCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      retriesLeft_q <= 3'h0;
    else if ((state_q == ST_OFF && state_d == ST_WAIT_ON) || (state_q != ST_RUN && state_d == ST_RUN))
      retriesLeft_q <= retryCode;
    else if (state_d == ST_RESTART_WAIT_PERIOD && state_q != ST_RESTART_WAIT_PERIOD && retryCode != prs_pkg::RETRY_FOREVER)
      retriesLeft_q <= retriesLeft_q - 3'h1;
  end

  // Power stage, reference and undervoltage arming
  assign refProduct = 32'(targetVoltage) * 32'(fallQuarters - 11'(quarterCnt_q) - 11'h001);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      energy_q   <= 1'b0;
      uvArm_q    <= 1'b0;
      refLevel_q <= 16'h0000;
    end
    else
    begin
      energy_q <= state_d inside {ST_RISE, ST_RESP_DELAY, ST_RUN, ST_STOP_DELAY, ST_LATENCY, ST_FALL};
      if (rampUpDone && state_q inside {ST_RISE, ST_RESP_DELAY, ST_RUN})
        uvArm_q <= 1'b1;
      else if (!(state_q inside {ST_RISE, ST_RESP_DELAY, ST_RUN}))
        uvArm_q <= 1'b0;
      if (state_q == ST_FALL && state_d == ST_FALL && quarterTick)
        refLevel_q <= 16'(refProduct / 32'(fallQuarters));
      else if (state_q == ST_FALL && state_d != ST_FALL)
        refLevel_q <= 16'h0000;
      else if (state_q != ST_FALL && energy_q)
        refLevel_q <= targetVoltage;
      else if (state_q != ST_FALL)
        refLevel_q <= 16'h0000;
    end
  end

  assign energyOn        = energy_q;
  assign undervoltageArm = uvArm_q;
  assign referenceLevel  = refLevel_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_timeout_flag;
    faultHit |=> voutTimeout_q && !alertN && status.summaryOther && status.summaryVout;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("timeout fault not flagged");

  property p_zero_limit;
    (state_q == ST_RISE && limitReg_q[10:0] == 11'h000 && !voutTimeout_q) |=> !voutTimeout_q;
  endproperty
  a_zero_limit: assert property (p_zero_limit) else $error("timeout fired with zero limit");

  property p_uv_arm;
    $rose(uvArm_q) |-> $past(rampUpDone);
  endproperty
  a_uv_arm: assert property (p_uv_arm) else $error("undervoltage armed without ramp end");

  property p_limit_write;
    wrLimit |=> invalidCmd_q && $stable(limitReg_q) ##1 !alertN;
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit write not refused");

  property p_bad_action;
    (wrAction && badAction) |=> invalidData_q && actionReg_q == $past(actionReg_q);
  endproperty
  a_bad_action: assert property (p_bad_action) else $error("invalid action stored");

  property p_bad_stop;
    (wrStop && badStop) |=> invalidData_q && $stable(stopReg_q);
  endproperty
  a_bad_stop: assert property (p_bad_stop) else $error("out of range stop delay stored");

  property p_immediate;
    (faultHit && actSel == prs_pkg::ACT_IMMEDIATE && runSync_q) |=> !energyOn;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate shutdown missed");

  property p_latch_off;
    (faultHit && actSel == prs_pkg::ACT_IMMEDIATE && retryCode == 3'h0 && runSync_q) |=> state_q == ST_LATCHED;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("no latch off with zero retries");

  property p_latency;
    (state_q == ST_STOP_DELAY && state_d == ST_LATENCY) |=> (state_q == ST_LATENCY) [*8];
  endproperty
  a_latency: assert property (p_latency) else $error("stop latency skipped");

  property p_fall_end;
    (state_q == ST_FALL && state_d == ST_OFF) |=> referenceLevel == 16'h0000 ##1 !energyOn;
  endproperty
  a_fall_end: assert property (p_fall_end) else $error("reference not zero after fall");

  c_good_start: cover property (state_q == ST_RISE ##1 state_q == ST_RUN);
  c_restart_wait_period_retry: cover property (state_q == ST_RESTART_WAIT_PERIOD ##1 state_q == ST_WAIT_ON);
  c_soft_off: cover property (state_q == ST_FALL ##1 state_q == ST_OFF);
  c_delayed: cover property (state_q == ST_RESP_DELAY ##1 state_q == ST_RESTART_WAIT_PERIOD);

endmodule : prs_sequence_timing

// ==== inc/prs_pkg.sv ====
// Constants and carrier types for the rail start/stop timing block
package prs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned QUARTER_MS_NS = 250000;
  localparam int unsigned QUARTER_MS_CYCLES = QUARTER_MS_NS / CLK_PERIOD_NS;
  localparam int unsigned LATENCY_NS = 50000;
  localparam int unsigned LATENCY_CYCLES = LATENCY_NS / CLK_PERIOD_NS;

  localparam logic [7:0] CMD_TIMEOUT_LIMIT = 8'h62;
  localparam logic [7:0] CMD_TIMEOUT_ACTION = 8'h63;
  localparam logic [7:0] CMD_STOP_DELAY = 8'h64;
  localparam logic [7:0] CMD_RAMP_DOWN = 8'h65;

  localparam int unsigned EXP_MSB = 15;
  localparam int unsigned EXP_LSB = 11;
  localparam int unsigned MAN_MSB = 10;
  localparam int unsigned ACT_SEL_LSB = 6;
  localparam int unsigned ACT_RETRY_LSB = 3;
  localparam int unsigned ACT_DELAY_LSB = 0;

  localparam logic [4:0] EXP_HALF_MS = 5'h1f;
  localparam logic [4:0] EXP_QUARTER_MS = 5'h1e;
  localparam logic [10:0] TIMEOUT_MAN_MAX = 11'h0fe;
  localparam logic [10:0] STOP_MAN_MAX = 11'h0ff;
  localparam logic [10:0] FALL_MAN_MAX = 11'h07f;
  localparam logic [10:0] FALL_MAN_MIN = 11'h002;
  localparam logic [10:0] RISE_MAN_MIN = 11'h002;

  localparam logic [10:0] TIMEOUT_MAN_RESET = 11'h014;
  localparam logic [7:0] ACTION_RESET = 8'h80;
  localparam logic [10:0] STOP_MAN_RESET = 11'h000;
  localparam logic [10:0] FALL_MAN_RESET = 11'h004;

  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int unsigned REACH_NUM = 85;
  localparam int unsigned REACH_DEN = 100;

  typedef enum logic [1:0] {
    ACT_IGNORE,
    ACT_DELAYED,
    ACT_IMMEDIATE,
    ACT_INVALID
  } prs_action_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } prs_cmd_t;

  typedef struct packed {
    logic voutTimeout;
    logic invalidCommand;
    logic invalidData;
    logic summaryOther;
    logic summaryVout;
    logic summaryCml;
  } prs_status_t;

endpackage : prs_pkg

// ==== testbench/prs_rail_model.sv ====
// Behavioural power stage and sense path that the timing block supervises
`timescale 1ns/1ps
module prs_rail_model (
  input  wire logic        clk,
  input  wire logic        energyOn,
  input  wire logic        slowRise,
  input  wire logic [15:0] targetVoltage,
  output logic      [15:0] outputVoltageTelemetry
);
  // A slow rail stalls at 80 percent so the start-up threshold is never met
  always_ff @(posedge clk)
  begin
    if (!energyOn)
      outputVoltageTelemetry <= 16'h0000;
    else if (slowRise)
      outputVoltageTelemetry <= 16'((32'(targetVoltage) * 80) / 100);
    else
      outputVoltageTelemetry <= targetVoltage;
  end
endmodule : prs_rail_model

// ==== testbench/test_prs_sequence_timing.sv ====
// Self-checking bench for the rail start/stop timing block
`timescale 1ns/1ps
module test_prs_sequence_timing;
  // Short quarter keeps every millisecond count affordable in simulation
  localparam int unsigned QC = 20;
  logic                 clk;
  logic                 rst;
  logic                 runRequest;
  logic                 turnOnWaitDone;
  logic                 rampUpDone;
  logic                 clearFaults;
  logic                 slowRise;
  logic                 cmdReadValid;
  logic                 energyOn;
  logic                 undervoltageArm;
  logic                 alertN;
  logic                 prevOn;
  logic [10:0]          rampUpQuarters;
  logic [15:0]          telemetry;
  logic [15:0]          targetVoltage;
  logic [15:0]          cmdReadData;
  logic [15:0]          referenceLevel;
  logic [7:0]           act;
  logic [23:0]          bad [3];
  prs_pkg::prs_cmd_t    cmd;
  prs_pkg::prs_status_t status;
  int                   nMismatch;
  int                   checked;
  int                   seed;
  int                   rises;
  int                   m;
  int                   r;

  prs_sequence_timing #(.QUARTER_CYCLES(QC)) uut (
    .clk(clk), .rst(rst), .runRequest(runRequest), .turnOnWaitDone(turnOnWaitDone),
    .rampUpDone(rampUpDone), .rampUpQuarters(rampUpQuarters), .outputVoltageTelemetry(telemetry),
    .targetVoltage(targetVoltage), .clearFaults(clearFaults), .cmd(cmd), .cmdReadData(cmdReadData),
    .cmdReadValid(cmdReadValid), .energyOn(energyOn), .undervoltageArm(undervoltageArm),
    .referenceLevel(referenceLevel), .status(status), .alertN(alertN)
  );

  prs_rail_model rail (
    .clk(clk), .energyOn(energyOn), .slowRise(slowRise), .targetVoltage(targetVoltage),
    .outputVoltageTelemetry(telemetry)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] expRises(input int retries);
    return 16'(retries + 1);
  endfunction : expRises

  // Linear soft-off: level after step k of n quarter steps
  function automatic logic [15:0] expRef(input logic [15:0] v, input int n, input int k);
    return 16'((int'(v) * (n - k - 1)) / n);
  endfunction : expRef

  // Two sync flops, the stop delay in quarters, then the fixed latency
  function automatic int stopCycles(input int man);
    return 2 + 2 * man * QC + prs_pkg::LATENCY_CYCLES;
  endfunction : stopCycles

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Idle edge first so valid never rises in the time step that lowered it
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data);
    step(1);
    cmd = '{valid: 1'b1, write: wr, code: code, data: data};
    step(1);
    cmd.valid = 1'b0;
  endtask : xfer

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    xfer(1'b0, code, 16'h0000);
    check({15'h0000, cmdReadValid}, 16'h0001, "read valid");
    check(cmdReadData, exp, "read data");
  endtask : rd

  task automatic clr();
    clearFaults = 1'b1;
    step(1);
    clearFaults = 1'b0;
    step(1);
  endtask : clr

  // Long enough for a full soft-off with the default stop and fall times
  task automatic stopRun();
    runRequest = 1'b0;
    step(3000);
    clr();
    check({15'h0000, alertN}, 16'h0001, "alert released");
  endtask : stopRun

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (60000) @(posedge clk);
    nMismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    seed = 28774;
    nMismatch = 0;
    checked = 0;
    rst = 1'b1;
    runRequest = 1'b0;
    turnOnWaitDone = 1'b1;
    rampUpDone = 1'b0;
    clearFaults = 1'b0;
    slowRise = 1'b1;
    rampUpQuarters = 11'h004;
    targetVoltage = 16'h0800 + 16'($unsigned($random(seed)) % 16'h0800);
    cmd = '0;
    bad = '{24'h64f900, 24'h64f0ff, 24'h6300c0};
    step(12);
    rst = 1'b0;
    rd(8'h62, 16'hf814);
    rd(8'h63, 16'h0080);
    rd(8'h64, 16'hf800);
    rd(8'h65, 16'hf004);
    xfer(1'b0, 8'h66, 16'h0000);
    check({15'h0000, cmdReadValid}, 16'h0000, "unmapped read");
    xfer(1'b1, 8'h62, 16'hf802);
    step(1);
    check({14'h0000, status.invalidCommand, alertN}, 16'h0002, "limit write refused");
    rd(8'h62, 16'hf814);
    foreach (bad[i])
    begin
      clr();
      xfer(1'b1, bad[i][23:16], bad[i][15:0]);
      step(1);
      check({14'h0000, status.invalidData, alertN}, 16'h0002, "bad data flagged");
    end
    rd(8'h64, 16'hf800);
    rd(8'h63, 16'h0080);
    $display("test registers done");

    clr();
    runRequest = 1'b1;
    step(790);
    check({15'h0000, energyOn}, 16'h0001, "on before limit");
    step(40);
    check({13'h0000, status.voutTimeout, status.summaryOther, status.summaryVout}, 16'h0007, "flags");
    check({14'h0000, alertN, energyOn}, 16'h0000, "immediate shutdown");
    step(200);
    check({15'h0000, energyOn}, 16'h0000, "latched off");
    stopRun();
    $display("test timeout shutdown done");

    xfer(1'b1, 8'h63, 16'h0000);
    clr();
    runRequest = 1'b1;
    step(20);
    check({15'h0000, undervoltageArm}, 16'h0000, "not armed in rise");
    rampUpDone = 1'b1;
    step(1);
    rampUpDone = 1'b0;
    step(2);
    check({15'h0000, undervoltageArm}, 16'h0001, "armed after rise");
    step(900);
    check({12'h000, status.voutTimeout, status.summaryOther, status.summaryVout, energyOn}, 16'h000f, "ignore");
    stopRun();
    $display("test ignore action done");

    // Third pass shuts down at once and retries without end
    for (int s = 1; s <= 3; s++)
    begin
      r = 1 + int'($unsigned($random(seed)) % 3);
      act = (s == 3) ? {2'h2, prs_pkg::RETRY_FOREVER, 3'h1} : {2'(s), 3'(r), 3'h1};
      xfer(1'b1, 8'h63, {8'h00, act});
      rd(8'h63, {8'h00, act});
      clr();
      runRequest = 1'b1;
      rises = 0;
      prevOn = 1'b0;
      repeat ((r + 1) * 1000 + 400)
      begin
        step(1);
        if (energyOn === 1'b1 && prevOn === 1'b0)
          rises++;
        prevOn = energyOn;
      end
      if (s == 3)
        check({15'h0000, rises > r + 1}, 16'h0001, "endless restarts");
      else
        check(16'(rises), expRises(r), "restart count");
      stopRun();
      $display("test retry mode %0d done", s);
    end

    slowRise = 1'b0;
    xfer(1'b1, 8'h63, 16'h0080);
    m = int'($unsigned($random(seed)) % 4);
    xfer(1'b1, 8'h64, 16'hf800 | 16'(m));
    xfer(1'b1, 8'h65, 16'hf002);
    rd(8'h64, 16'hf800 | 16'(m));
    clr();
    runRequest = 1'b1;
    step(900);
    check({14'h0000, status.voutTimeout, energyOn}, 16'h0001, "good start");
    runRequest = 1'b0;
    step(stopCycles(m) - 10);
    check({15'h0000, energyOn}, 16'h0001, "still on in stop delay");
    step(2 * QC);
    check(referenceLevel, expRef(targetVoltage, 2, 0), "reference mid fall");
    step(20);
    check({15'h0000, energyOn}, 16'h0000, "off after fall");
    check(referenceLevel, 16'h0000, "reference at zero");
    $display("test soft-off done");
    complete_run();
  end
endmodule : test_prs_sequence_timing
